/* rtl/rba_core.sv */
/*
 * Receive bit alignment and collision capture. Places decoded bits into
 * bytes from a programmable start position, reports the valid bits of the
 * last byte and captures the first collision position.
 * Assumes the receive decoder runs on clk and gives single-cycle strobes,
 * and that the register master follows the plain strobe port protocol.
 */
// Design decision made here: the address-and-strobe port.
// Overview of operation
// - Keep bit clear zeroes every bit received after a collision; set keeps them.
// - First bit lands at first_bit_position; later bits go to higher positions.
// - After bit 7 of a byte, the next bit goes to bit 0 of next byte.
// - Position zero means byte-oriented reception; any other value bit-oriented.
// - With collision_as_integrity_error set, a collision raises the integrity error flag.
// - last_byte_valid_bits counts valid bits of last byte; zero means whole byte.
// - Bit-oriented frame end loads valid bit count; reception start clears it.
// - Position valid flag set only for a captured, expressible collision position.
// - Position field holds bit index of first data-bit collision in the frame.
// - Only collisions within the first 8 bytes are reported as valid.
// - Position is zero-based: 00h first bit, 3Fh last bit of byte eight.
// - Nonzero first_bit_position is added into the reported collision position.
// - End-of-frame collisions set no flag and count as no data-bit collision.
// - Collision detected flag clears at the start of each reception phase.
`timescale 1ns/1ns
`include "rba_cfg.svh"

module rba_core
    import rba_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       rx_start,
    input  wire logic       rx_bit_vld,
    input  wire logic       rx_bit,
    input  wire logic       rx_bit_coll,
    input  wire logic       rx_eof_coll,
    input  wire logic       rx_end,
    output logic            out_byte_vld,
    output logic      [7:0] out_byte,
    output logic            coll_det,
    output logic            integ_err,
    output logic            bit_oriented
);

    // The sum can exceed the seven-bit field, so it is kept one bit wider.
    function automatic logic [7:0] rba_coll_pos(
        input logic [2:0] align,
        input logic [6:0] idx
    );
        rba_coll_pos = {1'b0, idx} + {5'h00, align};
    endfunction

    function automatic logic [7:0] rba_place(
        input logic [7:0] cur,
        input logic [2:0] ptr,
        input logic       b
    );
        logic [7:0] r;
        r = cur;
        r[ptr] = b;
        rba_place = r;
    endfunction

    rba_reg_req_t req;
    rba_rx_t      rx;
    rba_state_t   s;
    rba_state_t   next_s;

    assign req.addr_unused = 1'b0;
    assign req.addr        = reg_addr;
    assign req.wdata       = reg_wdata;
    assign req.wr          = reg_wr;
    assign req.rd          = reg_rd;
    assign rx.start        = rx_start;
    assign rx.bit_vld      = rx_bit_vld;
    assign rx.bit_val      = rx_bit;
    assign rx.bit_coll     = rx_bit_coll;
    assign rx.eof_coll     = rx_eof_coll;
    assign rx.done         = rx_end;

    always_comb
    begin
        logic [2:0] ptr_eff;
        logic [7:0] cur_eff;
        logic [7:0] cur_new;
        logic [7:0] pos_sum;
        logic       b;
        logic       data_coll;
        ptr_eff   = `RBA_RST_BITS;
        cur_eff   = `RBA_RST_BYTE;
        cur_new   = `RBA_RST_BYTE;
        pos_sum   = `RBA_RST_BYTE;
        b         = 1'b0;
        data_coll = 1'b0;

        next_s         = s;
        next_s.out.vld = 1'b0;
        next_s.rdata   = `RBA_RST_BYTE;

        if (req.rd)
        begin
            case (req.addr)
                `RBA_ADDR_BIT_CTRL:
                begin
                    next_s.rdata = {s.keep, s.align, s.no_coll, s.last_bits};
                end
                `RBA_ADDR_COLL_INFO:
                begin
                    next_s.rdata = {s.pos_valid, s.pos};
                end
                default:
                begin
                    next_s.rdata = `RBA_RST_BYTE;
                end
            endcase
        end

        if (req.wr && req.addr == `RBA_ADDR_BIT_CTRL)
        begin
            next_s.keep      = req.wdata[`RBA_KEEP_BIT];
            next_s.align     = req.wdata[`RBA_ALIGN_HI:`RBA_ALIGN_LO];
            next_s.no_coll   = req.wdata[`RBA_COLLISION_AS_INTEGRITY_ERROR_BIT];
            next_s.last_bits = req.wdata[`RBA_LAST_HI:`RBA_LAST_LO];
        end

        // A new reception wipes all per-frame results; a bit or frame end in
        // the same cycle is not applied on top and is lost.
        if (rx.start)
        begin
            next_s.st        = RBA_RX;
            next_s.last_bits = `RBA_RST_BITS;
            next_s.coll_det  = 1'b0;
            next_s.integ_err = 1'b0;
            next_s.pos_valid = 1'b0;
            next_s.pos       = `RBA_RST_POS;
            next_s.idx       = `RBA_RST_POS;
            next_s.any_coll  = 1'b0;
            next_s.started   = 1'b0;
            next_s.cur       = `RBA_RST_BYTE;
            next_s.ptr       = `RBA_RST_BITS;
        end
        else if (s.st == RBA_RX)
        begin
            if (rx.bit_vld)
            begin
                // The first bit takes the programmed start position.
                ptr_eff = s.started ? s.ptr : s.align;
                cur_eff = s.started ? s.cur : `RBA_RST_BYTE;
                b       = (s.any_coll && !s.keep) ? 1'b0 : rx.bit_val;
                cur_new = rba_place(cur_eff, ptr_eff, b);
                next_s.started = 1'b1;
                if (ptr_eff == `RBA_PTR_TOP)
                begin
                    next_s.out.vld  = 1'b1;
                    next_s.out.data = cur_new;
                    next_s.cur      = `RBA_RST_BYTE;
                    next_s.ptr      = `RBA_RST_BITS;
                end
                else
                begin
                    next_s.cur = cur_new;
                    next_s.ptr = ptr_eff + 3'h1;
                end

                // End-of-frame collisions are filtered out here.
                data_coll = rx.bit_coll && !rx.eof_coll;
                pos_sum   = rba_coll_pos(s.align, s.idx);
                if (data_coll)
                begin
                    next_s.coll_det = 1'b1;
                    if (s.no_coll)
                    begin
                        next_s.integ_err = 1'b1;
                    end
                    if (!s.any_coll)
                    begin
                        next_s.any_coll = 1'b1;
                        if (pos_sum <= `RBA_MAX_POS)
                        begin
                            next_s.pos_valid = 1'b1;
                            next_s.pos       = pos_sum[`RBA_POS_HI:`RBA_POS_LO];
                        end
                    end
                end

                // The index saturates so a long frame cannot wrap into range.
                if (s.idx != `RBA_IDX_MAX)
                begin
                    next_s.idx = s.idx + 7'h01;
                end
            end

            if (rx.done)
            begin
                next_s.st = RBA_IDLE;
                if (s.started && s.ptr != `RBA_RST_BITS)
                begin
                    next_s.out.vld  = 1'b1;
                    next_s.out.data = s.cur;
                end
                if (s.align != `RBA_ALIGN_BYTE)
                begin
                    // A pointer of zero means the last byte was full.
                    next_s.last_bits = s.started ? s.ptr : `RBA_RST_BITS;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s.st        <= RBA_IDLE;
            s.keep      <= 1'b0;
            s.align     <= `RBA_RST_BITS;
            s.no_coll   <= 1'b0;
            s.last_bits <= `RBA_RST_BITS;
            s.pos_valid <= 1'b0;
            s.pos       <= `RBA_RST_POS;
            s.idx       <= `RBA_RST_POS;
            s.any_coll  <= 1'b0;
            s.started   <= 1'b0;
            s.cur       <= `RBA_RST_BYTE;
            s.ptr       <= `RBA_RST_BITS;
            s.out.vld   <= 1'b0;
            s.out.data  <= `RBA_RST_BYTE;
            s.coll_det  <= 1'b0;
            s.integ_err <= 1'b0;
            s.rdata     <= `RBA_RST_BYTE;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign reg_rdata    = s.rdata;
    assign out_byte_vld = s.out.vld;
    assign out_byte     = s.out.data;
    assign coll_det     = s.coll_det;
    assign integ_err    = s.integ_err;
    assign bit_oriented = (s.align != `RBA_ALIGN_BYTE);

endmodule

/* shared/rba_cfg.svh */
/*
 * Register offsets, field positions, reset values and limits of the receive
 * bit alignment and collision capture block.
 * Assumes an 8-bit register port with byte offsets.
 */
`ifndef RBA_CFG_SVH
`define RBA_CFG_SVH

`define RBA_ADDR_BIT_CTRL   8'h0C
`define RBA_ADDR_COLL_INFO  8'h0D

`define RBA_KEEP_BIT        7
`define RBA_ALIGN_HI        6
`define RBA_ALIGN_LO        4
`define RBA_COLLISION_AS_INTEGRITY_ERROR_BIT      3
`define RBA_LAST_HI         2
`define RBA_LAST_LO         0
`define RBA_VALID_BIT       7
`define RBA_POS_HI          6
`define RBA_POS_LO          0

`define RBA_ALIGN_BYTE      3'h0
`define RBA_PTR_TOP         3'h7
`define RBA_MAX_POS         8'h3F
`define RBA_IDX_MAX         7'h7F
`define RBA_RST_BYTE        8'h00
`define RBA_RST_BITS        3'h0
`define RBA_RST_POS         7'h00

`endif

/* shared/rba_pkg.sv */
/*
 * Types of the receive bit alignment and collision capture block.
 * Assumes the constants of rba_cfg.svh for all numeric values.
 */
package rba_pkg;

    typedef enum logic [1:0] {
        RBA_IDLE = 2'b01,
        RBA_RX   = 2'b10
    } rba_fsm_t;

    typedef struct packed {
        logic       addr_unused;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rba_reg_req_t;

    typedef struct packed {
        logic start;
        logic bit_vld;
        logic bit_val;
        logic bit_coll;
        logic eof_coll;
        logic done;
    } rba_rx_t;

    typedef struct packed {
        logic       vld;
        logic [7:0] data;
    } rba_byte_t;

    typedef struct packed {
        rba_fsm_t   st;
        logic       keep;
        logic [2:0] align;
        logic       no_coll;
        logic [2:0] last_bits;
        logic       pos_valid;
        logic [6:0] pos;
        logic [6:0] idx;
        logic       any_coll;
        logic       started;
        logic [7:0] cur;
        logic [2:0] ptr;
        rba_byte_t  out;
        logic       coll_det;
        logic       integ_err;
        logic [7:0] rdata;
    } rba_state_t;

endpackage

/* tb/rba_core_assertions.sv */
/*
 * Concurrent checks on the ports of the receive bit alignment block.
 * Assumes the plain strobe register port and single-cycle receive strobes.
 */
`timescale 1ns/1ns

module rba_core_chk (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       rx_start,
    input wire logic       rx_bit_vld,
    input wire logic       rx_bit_coll,
    input wire logic       rx_eof_coll,
    input wire logic       rx_end,
    input wire logic       out_byte_vld,
    input wire logic       coll_det,
    input wire logic       integ_err,
    input wire logic       bit_oriented
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_mode_write: assert property (reg_wr && reg_addr == 8'h0C |=> bit_oriented == ($past(reg_wdata[6:4]) != 3'h0))
        else $error("bit oriented mode does not follow the alignment field");
    chk_start_clear: assert property (rx_start |=> !coll_det && !integ_err)
        else $error("flags not cleared at reception start");
    chk_flag_hold: assert property (coll_det && !rx_start |=> coll_det)
        else $error("collision flag dropped during a frame");
    chk_eof_ignore: assert property (rx_bit_vld && rx_eof_coll && !coll_det && !rx_start |=> !coll_det)
        else $error("end of frame collision set the flag");
    chk_integ_cause: assert property (integ_err |-> coll_det)
        else $error("integrity error without a collision");
    chk_byte_cause: assert property (out_byte_vld |-> $past(rx_bit_vld || rx_end))
        else $error("byte strobe without a bit or frame end");
    chk_pos_range: assert property (reg_rd && reg_addr == 8'h0D |=> !reg_rdata[7] || reg_rdata[6:0] <= 7'h3F)
        else $error("valid collision position beyond eight bytes");
    chk_info_clear: assert property (reg_rd && reg_addr == 8'h0D && !coll_det |=> reg_rdata == 8'h00)
        else $error("collision info set with no collision");

    cover property (rx_bit_vld && rx_bit_coll && !rx_eof_coll);
    cover property (out_byte_vld);
    cover property (integ_err);
endmodule

bind rba_core rba_core_chk rba_core_chk_inst (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rx_start, .rx_bit_vld, .rx_bit_coll, .rx_eof_coll, .rx_end, .out_byte_vld, .coll_det, .integ_err, .bit_oriented);

/* tb/rba_core_test.sv */
/*
 * Self-checking bench of the receive bit alignment block.
 * Assumes the decoder model drives the receive side and the bench the register port.
 */
`timescale 1ns/1ns

module rba_core_test;
    logic       clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, out_byte, seed = 8'h35;
    logic       rx_start, rx_bit_vld, rx_bit, rx_bit_coll, rx_eof_coll, rx_end;
    logic       out_byte_vld, coll_det, integ_err, bit_oriented;
    int         n_mismatch = 0, num_checks = 0;
    logic [7:0] got[$];

    always #5 clk = ~clk;
    always @(posedge clk) if (out_byte_vld === 1'b1) got.push_back(out_byte);

    rba_dec_model rba_dec_model_inst (.clk, .rx_start, .rx_bit_vld, .rx_bit, .rx_bit_coll, .rx_eof_coll, .rx_end);
    rba_core rba_core_inst (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_start, .rx_bit_vld,
        .rx_bit, .rx_bit_coll, .rx_eof_coll, .rx_end, .out_byte_vld, .out_byte, .coll_det, .integ_err, .bit_oriented);

    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction

    // Position counts from the start offset; beyond the eighth byte it is not reported.
    function automatic logic [7:0] exp_info(int al, int ci);
        return (ci < 0 || al + ci > 63) ? 8'h00 : {1'b1, 7'(al + ci)};
    endfunction

    task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("read data", exp, reg_rdata);
    endtask

    task automatic run(int al, int n, int ci, logic kp, logic nc, logic eof);
        logic [7:0] cur, ex[$];
        logic       b;
        int         p;
        cur = 8'h00;
        p = al;
        // A collision index past the end of the frame would never be sent, so it is folded into the frame.
        if (ci >= n) ci = ci % n;
        wr(8'h0C, {kp, 3'(al), nc, 3'h5});
        rba_dec_model_inst.drv(1, 0, 0, 0, 0, 0);
        got.delete();
        chk("bit oriented", {7'h0, al != 0}, {7'h0, bit_oriented});
        for (int i = 0; i < n; i++)
        begin
            b = rnd() > 8'h7F;
            rba_dec_model_inst.drv(0, 1, b, i == ci, 0, 0);
            cur[p % 8] = (!kp && ci >= 0 && i > ci) ? 1'b0 : b;
            if (p % 8 == 7)
            begin
                ex.push_back(cur);
                cur = 8'h00;
            end
            p++;
        end
        if (eof) rba_dec_model_inst.drv(0, 1, 1, 1, 1, 0);
        rba_dec_model_inst.drv(0, 0, 0, 0, 0, 1);
        rba_dec_model_inst.drv(0, 0, 0, 0, 0, 0);
        repeat (2) @(posedge clk);
        if (p % 8 != 0) ex.push_back(cur);
        if (!eof)
        begin
            chk("byte count", 8'(ex.size()), 8'(got.size()));
            foreach (ex[k]) chk("stored byte", ex[k], got[k]);
        end
        chk("collision flag", {7'h0, ci >= 0}, {7'h0, coll_det});
        chk("integrity flag", {7'h0, ci >= 0 && nc}, {7'h0, integ_err});
        rd(8'h0C, {kp, 3'(al), nc, al != 0 ? 3'(p % 8) : 3'h0});
        rd(8'h0D, exp_info(al, ci));
        $display("frame done align %0d bits %0d collision %0d", al, n, ci);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end

    initial
    begin
        logic [7:0] r;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h0C, 8'h00);
        rd(8'h0D, 8'h00);
        rd(8'h3A, 8'h00);
        run(7, 2, -1, 1, 0, 0);
        run(4, 6, 3, 0, 1, 0);
        run(0, 70, 63, 1, 1, 0);
        run(1, 70, 63, 0, 0, 0);
        run(0, 8, -1, 1, 0, 1);
        wr(8'h0D, 8'hFF);
        rd(8'h0D, 8'h00);
        repeat (24)
        begin
            r = rnd();
            run(r[2:0], 1 + rnd() % 40, r[3] ? r[7:4] : -1, r[4], r[5], 0);
        end
        stop_test();
    end
endmodule

/* tb/rba_dec_model.sv */
/*
 * Behavioural receive decoder that feeds decoded bits to the block.
 * Assumes the bench calls drv once per clock cycle, right after an edge.
 */
`timescale 1ns/1ns

module rba_dec_model (
    input  wire logic clk,
    output logic      rx_start,
    output logic      rx_bit_vld,
    output logic      rx_bit,
    output logic      rx_bit_coll,
    output logic      rx_eof_coll,
    output logic      rx_end
);
    initial {rx_start, rx_bit_vld, rx_bit, rx_bit_coll, rx_eof_coll, rx_end} = 6'h00;

    // An unqualified data line toggles so that a stale value is never mistaken for a bit.
    task automatic drv(input logic s, input logic v, input logic b, input logic c, input logic e, input logic n);
        @(posedge clk);
        rx_start <= s;
        rx_bit_vld <= v;
        rx_bit <= v ? b : ~rx_bit;
        rx_bit_coll <= c;
        rx_eof_coll <= e;
        rx_end <= n;
    endtask
endmodule
